// >>> wco_pkg.sv
// Constants and types for the watchdog-clear and complement execution block
`default_nettype none

package wco_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned BANK_W = 4;

    // ------------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] CLEAR_WATCHDOG_WORD   = 16'h0004;
    localparam logic [5:0]  COMPLEMENT_PREFIX     = 6'h07;
    localparam int unsigned PREFIX_MSB            = 15;
    localparam int unsigned PREFIX_LSB            = 10;
    localparam int unsigned DEST_BIT              = 9;
    localparam int unsigned ACCESS_BIT            = 8;
    localparam int unsigned FILE_MSB              = 7;
    localparam int unsigned FILE_LSB              = 0;

    // ------------------------------------------------------------------
    // Operand addressing
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACCESS_LOW_LIMIT      = 8'h5F;
    localparam logic [3:0]  ACCESS_LOW_BANK       = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH_BANK      = 4'hF;

    // ------------------------------------------------------------------
    // Reset values and the zero-result constant
    // ------------------------------------------------------------------
    localparam logic [15:0] WORD_RESET            = 16'h0000;
    localparam logic [11:0] ADDR_RESET            = 12'h000;
    localparam logic [7:0]  DATA_RESET            = 8'h00;
    localparam logic [7:0]  RESULT_ZERO           = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        WCO_IDLE,
        WCO_DECODE,
        WCO_READ,
        WCO_PROCESS,
        WCO_WRITE
    } wco_phase_e;

    typedef enum logic [1:0] {
        WCO_OP_NONE,
        WCO_OP_CLEAR_WATCHDOG,
        WCO_OP_COMPLEMENT
    } wco_op_e;

endpackage : wco_pkg

`default_nettype wire

// >>> wco_exec.sv
// Four-phase execution of the watchdog clear and register complement instructions
//
// Behaviour
// - Watchdog clear resets the watchdog counter and its postscaler to zero.
// - Watchdog clear sets timeout and power-down flags to one, nothing else.
// - Complement reads the addressed register and inverts all eight bits.
// - Destination bit 0 writes working register; 1 writes back to the register.
// - Access bit 0 uses access bank; 1 uses bank select register bank.
// - Access 0, extended set on, file address up to 5Fh: indexed literal offset.
`timescale 1ns/1ns
`default_nettype none

module wco_exec
    import wco_pkg::*;
(
    input  wire logic                         clock_i,
    input  wire logic                         rst_n_i,
    // Instruction hand-in
    input  wire logic                         instr_valid_i,
    input  wire logic [wco_pkg::WORD_W-1:0]   instr_word_i,
    output logic                              instr_ready_o,
    output logic                              instr_done_o,
    output logic                              instr_unknown_o,
    // Addressing context
    input  wire logic                         extended_set_en_i,
    input  wire logic [wco_pkg::BANK_W-1:0]   bank_select_register_i,
    input  wire logic [wco_pkg::ADDR_W-1:0]   index_base_i,
    // Data memory
    output logic [wco_pkg::ADDR_W-1:0]        mem_addr_o,
    output logic                              mem_rd_o,
    input  wire logic [wco_pkg::DATA_W-1:0]   mem_rdata_i,
    output logic                              mem_wr_o,
    output logic [wco_pkg::DATA_W-1:0]        mem_wdata_o,
    // Working register
    output logic                              w_wr_o,
    output logic [wco_pkg::DATA_W-1:0]        w_data_o,
    // Arithmetic status
    output logic                              status_wr_o,
    output logic                              negative_flag_o,
    output logic                              zero_flag_o,
    // Watchdog and reset-cause flags
    output logic                              watchdog_counter_clear_o,
    output logic                              watchdog_postscaler_clear_o,
    output logic                              timeout_flag_n_set_o,
    output logic                              powerdown_flag_n_set_o
);

    import wco_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    wco_phase_e              phase_r;
    wco_phase_e              phase_nxt;
    wco_op_e                 op_r;
    wco_op_e                 op_nxt;
    logic [WORD_W-1:0]       word_r;
    logic [WORD_W-1:0]       word_nxt;
    logic [ADDR_W-1:0]       addr_r;
    logic [ADDR_W-1:0]       addr_nxt;
    logic [DATA_W-1:0]       result_r;
    logic [DATA_W-1:0]       result_nxt;
    logic                    dest_file_r;
    logic                    dest_file_nxt;
    logic                    negative_r;
    logic                    negative_nxt;
    logic                    zero_r;
    logic                    zero_nxt;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    logic [7:0]              file_addr;
    logic                    access_bit;
    logic                    is_clear_watchdog;
    logic                    is_complement;
    logic [ADDR_W-1:0]       operand_addr;

    always_comb begin
        // Indexed mode replaces only the low part of the access window
        file_addr         = word_r[FILE_MSB:FILE_LSB];
        access_bit        = word_r[ACCESS_BIT];
        is_clear_watchdog = (word_r == CLEAR_WATCHDOG_WORD);
        is_complement     = (word_r[PREFIX_MSB:PREFIX_LSB] == COMPLEMENT_PREFIX);
        if (access_bit) begin
            operand_addr = {bank_select_register_i, file_addr};
        end else if (extended_set_en_i && (file_addr <= ACCESS_LOW_LIMIT)) begin
            operand_addr = ADDR_W'(index_base_i + {4'h0, file_addr});
        end else if (file_addr <= ACCESS_LOW_LIMIT) begin
            operand_addr = {ACCESS_LOW_BANK, file_addr};
        end else begin
            operand_addr = {ACCESS_HIGH_BANK, file_addr};
        end
    end

    // ------------------------------------------------------------------
    // Next-state computation
    // ------------------------------------------------------------------
    always_comb begin
        phase_nxt     = phase_r;
        op_nxt        = op_r;
        word_nxt      = word_r;
        addr_nxt      = addr_r;
        result_nxt    = result_r;
        dest_file_nxt = dest_file_r;
        negative_nxt  = negative_r;
        zero_nxt      = zero_r;
        unique case (phase_r)
            WCO_IDLE: begin
                // Word latched so the source may change it after the take
                if (instr_valid_i) begin
                    word_nxt  = instr_word_i;
                    phase_nxt = WCO_DECODE;
                end
            end
            WCO_DECODE: begin
                // Unknown words run the full slot as a no-op
                if (is_clear_watchdog) begin
                    op_nxt = WCO_OP_CLEAR_WATCHDOG;
                end else if (is_complement) begin
                    op_nxt = WCO_OP_COMPLEMENT;
                end else begin
                    op_nxt = WCO_OP_NONE;
                end
                addr_nxt      = operand_addr;
                dest_file_nxt = word_r[DEST_BIT];
                phase_nxt     = WCO_READ;
            end
            WCO_READ: begin
                // Read data is sampled only at the end of this phase
                if (op_r == WCO_OP_COMPLEMENT) begin
                    result_nxt = ~mem_rdata_i;
                end
                phase_nxt = WCO_PROCESS;
            end
            WCO_PROCESS: begin
                // Flags from the registered result, visible in the write phase
                if (op_r == WCO_OP_COMPLEMENT) begin
                    negative_nxt = result_r[DATA_W-1];
                    zero_nxt     = (result_r == RESULT_ZERO);
                end
                phase_nxt = WCO_WRITE;
            end
            WCO_WRITE: begin
                phase_nxt = WCO_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r     <= WCO_IDLE;
            op_r        <= WCO_OP_NONE;
            word_r      <= WORD_RESET;
            addr_r      <= ADDR_RESET;
            result_r    <= DATA_RESET;
            dest_file_r <= 1'b0;
            negative_r  <= 1'b0;
            zero_r      <= 1'b0;
        end else begin
            phase_r     <= phase_nxt;
            op_r        <= op_nxt;
            word_r      <= word_nxt;
            addr_r      <= addr_nxt;
            result_r    <= result_nxt;
            dest_file_r <= dest_file_nxt;
            negative_r  <= negative_nxt;
            zero_r      <= zero_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Phase strobes
    // ------------------------------------------------------------------
    logic                    comp_op;
    logic                    clear_op;
    logic                    in_read;
    logic                    in_process;
    logic                    in_write;

    // Decoded once so every pulse is tied to its own phase
    always_comb begin
        comp_op    = (op_r == WCO_OP_COMPLEMENT);
        clear_op   = (op_r == WCO_OP_CLEAR_WATCHDOG);
        in_read    = (phase_r == WCO_READ);
        in_process = (phase_r == WCO_PROCESS);
        in_write   = (phase_r == WCO_WRITE);
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Ready only in idle; words offered while busy are ignored
    assign instr_ready_o   = (phase_r == WCO_IDLE);
    assign instr_done_o    = in_write;
    assign instr_unknown_o = in_write && (op_r == WCO_OP_NONE);

    assign mem_addr_o      = addr_r;
    assign mem_rd_o        = in_read && comp_op;
    assign mem_wdata_o     = result_r;
    // Write strobes are exclusive on the destination bit
    assign mem_wr_o        = in_write && comp_op && dest_file_r;
    assign w_data_o        = result_r;
    assign w_wr_o          = in_write && comp_op && !dest_file_r;

    // Status update belongs to complement only
    assign status_wr_o     = in_write && comp_op;
    assign negative_flag_o = negative_r;
    assign zero_flag_o     = zero_r;

    // Watchdog clear acts in the process phase only
    assign watchdog_counter_clear_o    = in_process && clear_op;
    assign watchdog_postscaler_clear_o = in_process && clear_op;
    assign timeout_flag_n_set_o        = in_process && clear_op;
    assign powerdown_flag_n_set_o      = in_process && clear_op;

endmodule : wco_exec

`default_nettype wire

// >>> wco_exec_props.sv
// Concurrent checks for the watchdog clear and complement block
`timescale 1ns/1ns
`default_nettype none
module wco_exec_props
    import wco_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        instr_valid_i,
    input wire logic [15:0] instr_word_i,
    input wire logic        extended_set_en_i,
    input wire logic [3:0]  bank_select_register_i,
    input wire logic [11:0] index_base_i,
    input wire logic [11:0] mem_addr_o,
    input wire logic        instr_ready_o,
    input wire logic        instr_done_o,
    input wire logic        instr_unknown_o,
    input wire logic        mem_rd_o,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic        mem_wr_o,
    input wire logic [7:0]  mem_wdata_o,
    input wire logic        w_wr_o,
    input wire logic        status_wr_o,
    input wire logic        watchdog_counter_clear_o,
    input wire logic        watchdog_postscaler_clear_o,
    input wire logic        timeout_flag_n_set_o,
    input wire logic        powerdown_flag_n_set_o
);
    import wco_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // Accepted instructions
    // ----
    sequence s_take; instr_valid_i && instr_ready_o; endsequence
    sequence s_clr; s_take ##0 instr_word_i == CLEAR_WATCHDOG_WORD; endsequence
    sequence s_cmp; s_take ##0 instr_word_i[15:10] == COMPLEMENT_PREFIX; endsequence
    property p_clr; s_clr |-> ##3 watchdog_counter_clear_o && watchdog_postscaler_clear_o; endproperty
    a_clr: assert property (p_clr) else $error("watchdog clear pulse missing");
    property p_flg; s_clr |-> ##3 timeout_flag_n_set_o && powerdown_flag_n_set_o; endproperty
    a_flg: assert property (p_flg) else $error("flag set pulse missing");
    property p_nst; s_clr |-> ##4 instr_done_o && !status_wr_o; endproperty
    a_nst: assert property (p_nst) else $error("status touched by watchdog clear");
    property p_rd; s_cmp |-> ##2 mem_rd_o; endproperty
    a_rd: assert property (p_rd) else $error("operand read missing");
    property p_inv; mem_rd_o |=> mem_wdata_o == ~$past(mem_rdata_i); endproperty
    a_inv: assert property (p_inv) else $error("result is not the inverse");
    property p_dw; s_cmp ##0 !instr_word_i[DEST_BIT] |-> ##4 w_wr_o && !mem_wr_o; endproperty
    a_dw: assert property (p_dw) else $error("working register write wrong");
    property p_df; s_cmp ##0 instr_word_i[DEST_BIT] |-> ##4 mem_wr_o && !w_wr_o; endproperty
    a_df: assert property (p_df) else $error("write back wrong");
    property p_unk;
        s_take ##0 (instr_word_i != CLEAR_WATCHDOG_WORD && instr_word_i[15:10] != COMPLEMENT_PREFIX)
            |-> ##4 instr_unknown_o && !mem_wr_o && !w_wr_o;
    endproperty
    a_unk: assert property (p_unk) else $error("unknown word not flagged");
    property p_rdy; s_take |=> !instr_ready_o [*4] ##1 instr_ready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not low for the slot");
    property p_bank;
        s_cmp ##0 instr_word_i[ACCESS_BIT]
            |-> ##2 mem_addr_o == {$past(bank_select_register_i), 8'($past(instr_word_i, 2))};
    endproperty
    a_bank: assert property (p_bank) else $error("banked operand address wrong");
    sequence s_low; s_cmp ##0 !instr_word_i[ACCESS_BIT] && instr_word_i[7:0] <= ACCESS_LOW_LIMIT; endsequence
    property p_idx;
        s_low ##1 extended_set_en_i
            |=> mem_addr_o == 12'($past(index_base_i) + {4'h0, 8'($past(instr_word_i, 2))});
    endproperty
    a_idx: assert property (p_idx) else $error("indexed operand address wrong");
endmodule : wco_exec_props
bind wco_exec wco_exec_props wco_exec_props_inst (
    .clock_i                     (clock_i),
    .rst_n_i                     (rst_n_i),
    .instr_valid_i               (instr_valid_i),
    .instr_word_i                (instr_word_i),
    .extended_set_en_i           (extended_set_en_i),
    .bank_select_register_i      (bank_select_register_i),
    .index_base_i                (index_base_i),
    .mem_addr_o                  (mem_addr_o),
    .instr_ready_o               (instr_ready_o),
    .instr_done_o                (instr_done_o),
    .instr_unknown_o             (instr_unknown_o),
    .mem_rd_o                    (mem_rd_o),
    .mem_rdata_i                 (mem_rdata_i),
    .mem_wr_o                    (mem_wr_o),
    .mem_wdata_o                 (mem_wdata_o),
    .w_wr_o                      (w_wr_o),
    .status_wr_o                 (status_wr_o),
    .watchdog_counter_clear_o    (watchdog_counter_clear_o),
    .watchdog_postscaler_clear_o (watchdog_postscaler_clear_o),
    .timeout_flag_n_set_o        (timeout_flag_n_set_o),
    .powerdown_flag_n_set_o      (powerdown_flag_n_set_o)
);
`default_nettype wire

// >>> wco_exec_bench.sv
// Directed bench for the watchdog clear and complement block
`timescale 1ns/1ns
`default_nettype none
module wco_exec_bench;
    import wco_pkg::*;
    logic clock_i, rst_n_i, instr_valid_i, extended_set_en_i, instr_ready_o, instr_done_o, instr_unknown_o;
    logic mem_rd_o, mem_wr_o, w_wr_o, status_wr_o, negative_flag_o, zero_flag_o, gr;
    logic watchdog_counter_clear_o, watchdog_postscaler_clear_o, timeout_flag_n_set_o, powerdown_flag_n_set_o;
    logic [15:0] instr_word_i;
    logic [3:0]  bank_select_register_i, gc;
    logic [11:0] index_base_i, mem_addr_o, ga;
    logic [7:0]  mem_rdata_i, mem_wdata_o, w_data_o, gd, gw;
    logic [6:0]  gf;
    int          error_cnt = 0;
    int          checks_done = 0;
    wco_exec wco_exec_inst (
        .clock_i                     (clock_i),
        .rst_n_i                     (rst_n_i),
        .instr_valid_i               (instr_valid_i),
        .instr_word_i                (instr_word_i),
        .instr_ready_o               (instr_ready_o),
        .instr_done_o                (instr_done_o),
        .instr_unknown_o             (instr_unknown_o),
        .extended_set_en_i           (extended_set_en_i),
        .bank_select_register_i      (bank_select_register_i),
        .index_base_i                (index_base_i),
        .mem_addr_o                  (mem_addr_o),
        .mem_rd_o                    (mem_rd_o),
        .mem_rdata_i                 (mem_rdata_i),
        .mem_wr_o                    (mem_wr_o),
        .mem_wdata_o                 (mem_wdata_o),
        .w_wr_o                      (w_wr_o),
        .w_data_o                    (w_data_o),
        .status_wr_o                 (status_wr_o),
        .negative_flag_o             (negative_flag_o),
        .zero_flag_o                 (zero_flag_o),
        .watchdog_counter_clear_o    (watchdog_counter_clear_o),
        .watchdog_postscaler_clear_o (watchdog_postscaler_clear_o),
        .timeout_flag_n_set_o        (timeout_flag_n_set_o),
        .powerdown_flag_n_set_o      (powerdown_flag_n_set_o)
    );
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Offer one word, then sample the read, process and write phases
    task automatic run(input logic [15:0] w, input logic [7:0] rd, input logic ext);
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        instr_word_i <= w;
        mem_rdata_i <= rd;
        extended_set_en_i <= ext;
        #1 chk({15'h0, instr_ready_o}, 16'h0001);
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        @(posedge clock_i);
        #1 {ga, gr} = {mem_addr_o, mem_rd_o};
        chk({15'h0, instr_ready_o}, 16'h0000);
        @(posedge clock_i);
        #1 {gd, gw} = {mem_wdata_o, w_data_o};
        gc = {watchdog_counter_clear_o, watchdog_postscaler_clear_o, timeout_flag_n_set_o, powerdown_flag_n_set_o};
        @(posedge clock_i);
        #1 gf = {instr_done_o, instr_unknown_o, mem_wr_o, w_wr_o, status_wr_o, negative_flag_o, zero_flag_o};
    endtask : run
    task automatic cmp(input logic d, a, ext, input logic [7:0] f, rd, input logic [11:0] ea);
        run({COMPLEMENT_PREFIX, d, a, f}, rd, ext);
        chk({4'h0, ga}, {4'h0, ea});
        chk({11'h0, gc, gr}, 16'h0001);
        chk({gd, gw}, {~rd, ~rd});
        chk({9'h0, gf}, {9'h0, 2'b10, d, !d, 1'b1, !rd[7], rd == 8'hFF});
    endtask : cmp
    task automatic t_clear();
        run(CLEAR_WATCHDOG_WORD, 8'hA5, 1'b0);
        chk({12'h0, gc}, 16'h000F);
        chk({10'h0, gr, gf[6:2]}, 16'h0010);
        $display("clear test done");
    endtask : t_clear
    task automatic t_bank();
        cmp(1'b1, 1'b1, 1'b0, 8'h13, 8'h13, 12'h513);
        cmp(1'b0, 1'b1, 1'b1, 8'h20, 8'h80, 12'h520);
        $display("bank test done");
    endtask : t_bank
    task automatic t_access();
        cmp(1'b0, 1'b0, 1'b0, 8'h10, 8'hFF, 12'h010);
        cmp(1'b1, 1'b0, 1'b0, 8'h80, 8'h00, 12'hF80);
        $display("access test done");
    endtask : t_access
    task automatic t_indexed();
        cmp(1'b1, 1'b0, 1'b1, 8'h5F, 8'h5A, 12'h14F);
        cmp(1'b0, 1'b0, 1'b1, 8'h60, 8'h01, 12'hF60);
        $display("indexed test done");
    endtask : t_indexed
    task automatic t_unknown();
        run(16'h0005, 8'h00, 1'b0);
        chk({11'h0, gc, gr}, 16'h0000);
        chk({11'h0, gf[6:2]}, 16'h0018);
        $display("unknown test done");
    endtask : t_unknown
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        {rst_n_i, instr_valid_i, extended_set_en_i, instr_word_i, mem_rdata_i} <= '0;
        bank_select_register_i <= 4'h5;
        index_base_i <= 12'h0F0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_clear();
        t_bank();
        t_access();
        t_indexed();
        t_unknown();
        summarize();
    end
    initial begin
        repeat (1000) @(posedge clock_i);
        error_cnt++;
        summarize();
    end
endmodule : wco_exec_bench
`default_nettype wire
